//--- hw/tmc_channel.v
// tmc_channel.v: configuration and evaluation of one temperature monitor channel
// assumes a front end giving a raw quarter-degree sample with a strobe and fault flags
//
// Behaviour
// - hold a 14-bit emission-factor code, round(4572 / factor), passed to front end.
// - topology 00 off, 01 beta PNP, 10 differential, 11 single-ended.
// - offset is 9-bit two's complement, quarter-degree step.
// - offset added before readout and both alarm comparisons.
// - two alarm comparators, 9-bit signed thresholds in whole degrees.
// - open and short detection only on remote diode channels.
// - polarity 0 gives short 0x3ff, open 0x401; polarity 1 swaps them.
// - exponential average, coefficient 1, 8 or 16; code 11 treated as 1.
// - alarm depth is the 4-bit setting plus one.
// - 7-bit signed hysteresis shifts the trip level while alarmed.
// - averaged, corrected reading is presented for the I2C read path.
// - any configuration write restarts measurement, averaging and alarms.
// - three channels, two remote and one internal, nine registers each.
`default_nettype none
`include "tmc_defines.vh"
module tmc_channel #(
    parameter REMOTE = 1                       // 1 for external diode, 0 for on-chip sensor
) (
    input  wire        I_CLK,                  // 25 MHz system clock
    input  wire        I_RST_N,                // synchronous reset, low active
    input  wire        I_CFG_WR,               // strobe: configuration written over I2C
    input  wire [13:0] I_EMIT_CODE,            // emission-factor code
    input  wire [1:0]  I_TOPOLOGY,             // diode topology select
    input  wire [8:0]  I_OFFSET,               // offset, quarter degrees, signed
    input  wire [8:0]  I_ALARM_A_THRESHOLD,    // alarm a threshold, signed degrees
    input  wire [8:0]  I_ALARM_B_THRESHOLD,    // alarm b threshold, signed degrees
    input  wire        I_FAULT_READING_POLARITY, // swaps forced fault codes
    input  wire [1:0]  I_AVERAGE_COEFFICIENT_SELECT, // averaging coefficient
    input  wire [3:0]  I_ALARM_A_DEPTH,        // alarm a filter setting
    input  wire [3:0]  I_ALARM_B_DEPTH,        // alarm b filter setting
    input  wire [6:0]  I_ALARM_A_HYSTERESIS,   // alarm a hysteresis, signed degrees
    input  wire [6:0]  I_ALARM_B_HYSTERESIS,   // alarm b hysteresis, signed degrees
    input  wire        I_SAMPLE_VLD,           // front end: new sample strobe
    input  wire [10:0] I_SAMPLE,               // front end: raw temperature, quarter degrees
    input  wire        I_DIODE_OPEN,           // front end: open diode (async)
    input  wire        I_DIODE_SHORT,          // front end: shorted diode (async)
    output reg  [13:0] O_EMIT_CODE,            // emission code to front end
    output reg  [1:0]  O_TOPOLOGY,             // topology to front end
    output reg         O_FE_RESTART,           // pulse: front end restart
    output reg  [10:0] O_TEMP,                 // reading for the I2C read path
    output reg         O_TEMP_VLD,             // pulse: reading updated
    output reg         O_ALARM_COMPARATOR_A,   // alarm a level
    output reg         O_ALARM_COMPARATOR_B    // alarm b level
);
    // sign-extending arithmetic right shift of the 20-bit accumulator difference
    function [19:0] asr;
        input [19:0] v;
        input [2:0]  s;
        begin
            asr = $signed(v) >>> s;
        end
    endfunction

    // right-shift amount of one averaging step for the coefficient select
    function [2:0] avg_shift;
        input [1:0] sel;
        begin
            case (sel)
                `TMC_AVG_8:  avg_shift = `TMC_AVG_8_SHIFT;
                `TMC_AVG_16: avg_shift = `TMC_AVG_16_SHIFT;
                default:     avg_shift = 3'h0;
            endcase
        end
    endfunction

    // forced reading of a diode fault; polarity 1 swaps the two codes
    function [10:0] fault_code;
        input pol;
        input is_short;
        begin
            if (pol ^ is_short) begin
                fault_code = `TMC_CODE_HOT;
            end else begin
                fault_code = `TMC_CODE_COLD;
            end
        end
    endfunction

    reg  [1:0]  open_sync_q;
    reg  [1:0]  short_sync_q;
    reg  [19:0] acc_q;
    reg         primed_q;
    reg         stb_q;
    reg  [10:0] corr_q;
    reg  [19:0] acc_d;
    reg  [2:0]  shift;
    wire        enabled = (I_TOPOLOGY != `TMC_TOPO_OFF);
    // a write or a disabled channel restarts averaging and both alarms
    wire        clear   = I_CFG_WR | ~enabled;
    wire        f_open;
    wire        f_short;
    // fault samples leave both alarms as they stand
    wire        alarm_stb = stb_q & ~f_open & ~f_short;
    wire [10:0] offs_ext = {{2{I_OFFSET[8]}}, I_OFFSET};
    // 11-bit wrap, the reading format has no room for an overflow bit
    wire [10:0] sum     = I_SAMPLE + offs_ext;
    wire [19:0] samp_w  = {{9{corr_q[10]}}, corr_q};
    wire        a_alarm;
    wire        b_alarm;

    always @* begin
        shift = avg_shift(I_AVERAGE_COEFFICIENT_SELECT);
        // accumulator holds the average scaled by 16
        if (!primed_q) begin
            acc_d = {samp_w[15:0], 4'h0};
        end else begin
            acc_d = acc_q + asr({samp_w[15:0], 4'h0} - acc_q, shift);
        end
    end

    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            open_sync_q  <= 2'b00;
            short_sync_q <= 2'b00;
        end else begin
            open_sync_q  <= {open_sync_q[0], I_DIODE_OPEN};
            short_sync_q <= {short_sync_q[0], I_DIODE_SHORT};
        end
    end

    // the on-chip sensor has no diode to open or short, so its fault flags stay low
    generate
        if (REMOTE != 0) begin : g_remote
            assign f_open  = open_sync_q[1];
            assign f_short = short_sync_q[1];
        end else begin : g_internal
            assign f_open  = 1'b0;
            assign f_short = 1'b0;
        end
    endgenerate

    // front end follows the configuration one cycle behind
    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_EMIT_CODE  <= `TMC_EMIT_RST;
            O_TOPOLOGY   <= `TMC_TOPO_RST;
            O_FE_RESTART <= 1'b0;
        end else begin
            O_EMIT_CODE  <= I_EMIT_CODE;
            O_TOPOLOGY   <= I_TOPOLOGY;
            O_FE_RESTART <= I_CFG_WR;
        end
    end

    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            acc_q      <= 20'h00000;
            primed_q   <= 1'b0;
            stb_q      <= 1'b0;
            corr_q     <= 11'h000;
            O_TEMP     <= 11'h000;
            O_TEMP_VLD <= 1'b0;
        end else if (clear) begin
            acc_q      <= 20'h00000;
            primed_q   <= 1'b0;
            stb_q      <= 1'b0;
            O_TEMP_VLD <= 1'b0;
        end else begin
            stb_q      <= I_SAMPLE_VLD;
            O_TEMP_VLD <= 1'b0;
            if (I_SAMPLE_VLD) begin
                corr_q <= sum;
            end
            // faults are judged when the sample is used, after the pin synchroniser
            if (stb_q) begin
                O_TEMP_VLD <= 1'b1;
                if (f_short || f_open) begin
                    O_TEMP <= fault_code(I_FAULT_READING_POLARITY, f_short);
                end else begin
                    acc_q    <= acc_d;
                    primed_q <= 1'b1;
                    O_TEMP   <= acc_d[14:4];
                end
            end
        end
    end

    tmc_alarm u_alarm_a (
        .i_clk    (I_CLK),
        .i_rst_n  (I_RST_N),
        .i_clear  (clear),
        .i_sample (alarm_stb),
        .i_temp   (corr_q),
        .i_thresh (I_ALARM_A_THRESHOLD),
        .i_hyst   (I_ALARM_A_HYSTERESIS),
        .i_depth  (I_ALARM_A_DEPTH),
        .o_alarm  (a_alarm)
    );

    tmc_alarm u_alarm_b (
        .i_clk    (I_CLK),
        .i_rst_n  (I_RST_N),
        .i_clear  (clear),
        .i_sample (alarm_stb),
        .i_temp   (corr_q),
        .i_thresh (I_ALARM_B_THRESHOLD),
        .i_hyst   (I_ALARM_B_HYSTERESIS),
        .i_depth  (I_ALARM_B_DEPTH),
        .o_alarm  (b_alarm)
    );

    always @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_ALARM_COMPARATOR_A <= 1'b0;
            O_ALARM_COMPARATOR_B <= 1'b0;
        end else begin
            // alarms drop two cycles after a write, as the comparators clear first
            O_ALARM_COMPARATOR_A <= a_alarm & enabled;
            O_ALARM_COMPARATOR_B <= b_alarm & enabled;
        end
    end
endmodule
`default_nettype wire

//--- hw/tmc_defines.vh
// tmc_defines.vh: constants of the temperature monitor channel logic
// assumes inclusion by bare name from the design files under hw/
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

`define TMC_TOPO_OFF       2'b00
`define TMC_TOPO_BETA      2'b01
`define TMC_TOPO_DIFF      2'b10
`define TMC_TOPO_SINGLE    2'b11
`define TMC_AVG_1          2'b00
`define TMC_AVG_8          2'b01
`define TMC_AVG_16         2'b10
`define TMC_AVG_8_SHIFT    3'h3
`define TMC_AVG_16_SHIFT   3'h4
`define TMC_CODE_HOT       11'h3ff
`define TMC_CODE_COLD      11'h401
`define TMC_TEMP_W         11
`define TMC_EMIT_RST       14'h11dc
`define TMC_TOPO_RST       2'b01
`define TMC_OFFS_RST       9'h000
`define TMC_THR_A_RST      9'h055
`define TMC_THR_B_RST      9'h1f6
`define TMC_DEPTH_RST      4'h0
`define TMC_HYST_RST       7'h00

`endif

//--- hw/tmc_alarm.v
// tmc_alarm.v: one alarm comparator with hysteresis and depth filter
// assumes samples in quarter degrees, one strobe per new sample
`default_nettype none
module tmc_alarm (
    input  wire        i_clk,       // system clock
    input  wire        i_rst_n,     // synchronous reset, low active
    input  wire        i_clear,     // restart alarm state
    input  wire        i_sample,    // new sample strobe
    input  wire [10:0] i_temp,      // corrected temperature, quarter degrees
    input  wire [8:0]  i_thresh,    // threshold, whole degrees, signed
    input  wire [6:0]  i_hyst,      // hysteresis, whole degrees, signed
    input  wire [3:0]  i_depth,     // filter setting, depth is setting plus one
    output reg         o_alarm      // filtered alarm level
);
    wire signed [12:0] temp_s  = {{2{i_temp[10]}}, i_temp};
    wire signed [12:0] thr_s   = {{2{i_thresh[8]}}, i_thresh, 2'b00};
    wire signed [12:0] hyst_s  = {{4{i_hyst[6]}}, i_hyst, 2'b00};
    // while alarmed the trip level moves by the hysteresis
    wire signed [12:0] level_s = o_alarm ? (thr_s + hyst_s) : thr_s;
    wire               raw     = (temp_s > level_s);
    reg  [3:0]         cnt_q;

    always @(posedge i_clk) begin
        if (!i_rst_n || i_clear) begin
            o_alarm <= 1'b0;
            cnt_q   <= 4'h0;
        end else if (i_sample) begin
            if (raw == o_alarm) begin
                cnt_q <= 4'h0;
            end else if (cnt_q >= i_depth) begin
                o_alarm <= raw;
                cnt_q   <= 4'h0;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/tmc_checker.sv
// tmc_checker.sv: port timing checks for tmc_channel
// assumes a bind onto tmc_channel, one clock, synchronous low reset
`default_nettype none
module tmc_checker (
    input wire logic        I_CLK,                // clock
    input wire logic        I_RST_N,              // reset
    input wire logic        I_CFG_WR,             // config write
    input wire logic [13:0] I_EMIT_CODE,          // emission in
    input wire logic [1:0]  I_TOPOLOGY,           // topology in
    input wire logic        I_SAMPLE_VLD,         // sample strobe
    input wire logic [13:0] O_EMIT_CODE,          // emission out
    input wire logic [1:0]  O_TOPOLOGY,           // topology out
    input wire logic        O_FE_RESTART,         // restart
    input wire logic [10:0] O_TEMP,               // reading
    input wire logic        O_TEMP_VLD,           // reading strobe
    input wire logic        O_ALARM_COMPARATOR_A, // alarm a
    input wire logic        O_ALARM_COMPARATOR_B  // alarm b
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    // sample accepted: channel on, not in or just after a config write
    sequence s_take;
        I_SAMPLE_VLD && I_TOPOLOGY != 2'h0 && !I_CFG_WR && !$past(I_CFG_WR);
    endsequence
    sequence s_off;
        (I_TOPOLOGY == 2'h0) [*4];
    endsequence
    reset_values_a: assert property ($rose(I_RST_N) |-> O_EMIT_CODE == 14'h11dc && O_TOPOLOGY == 2'h1)
        else $error("outputs not at reset values");
    output_copy_a: assert property ($past(I_RST_N) |-> O_EMIT_CODE == $past(I_EMIT_CODE) &&
        O_TOPOLOGY == $past(I_TOPOLOGY)) else $error("config copy wrong");
    cfg_restart_a: assert property (I_CFG_WR |=> O_FE_RESTART ##1 (!O_ALARM_COMPARATOR_A && !O_ALARM_COMPARATOR_B))
        else $error("config write did not restart");
    temp_answer_a: assert property (s_take |-> ##2 O_TEMP_VLD) else $error("reading strobe missing");
    temp_cause_a: assert property (O_TEMP_VLD |-> $past(I_SAMPLE_VLD, 2)) else $error("reading without sample");
    temp_hold_a: assert property ($changed(O_TEMP) |-> O_TEMP_VLD) else $error("reading moved unflagged");
    off_quiet_a: assert property (s_off |-> !O_ALARM_COMPARATOR_A && !O_ALARM_COMPARATOR_B && !O_TEMP_VLD)
        else $error("disabled channel active");
    alarm_timing_a: assert property ($rose(O_ALARM_COMPARATOR_A) || $rose(O_ALARM_COMPARATOR_B) |->
        $past(I_SAMPLE_VLD, 3)) else $error("alarm rose off sample");
endmodule
bind tmc_channel tmc_checker u_tmc_checker (.I_CLK, .I_RST_N, .I_CFG_WR, .I_EMIT_CODE, .I_TOPOLOGY, .I_SAMPLE_VLD,
    .O_EMIT_CODE, .O_TOPOLOGY, .O_FE_RESTART, .O_TEMP, .O_TEMP_VLD, .O_ALARM_COMPARATOR_A, .O_ALARM_COMPARATOR_B);
`default_nettype wire

//--- sim/tmc_front_end.sv
// tmc_front_end.sv: diode front end model giving one sample per request
// assumes requests from the bench just after a rising edge
`default_nettype none
module tmc_front_end (
    input  wire logic        i_clk,    // clock
    input  wire logic        i_go,     // request one conversion
    input  wire logic [10:0] i_value,  // temperature to report
    output var  logic        o_vld,    // sample strobe
    output var  logic [10:0] o_sample  // sample, toggles outside strobes
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_vld = 1'h0;
        o_sample = 11'h000;
    end
    // outside a strobe the data line never holds the last value
    always @(posedge i_clk) begin
        o_vld <= i_go;
        o_sample <= i_go ? i_value : ~o_sample;
    end
endmodule
`default_nettype wire

//--- sim/tmc_channel_bench.sv
// tmc_channel_bench.sv: self-checking bench for a remote and an internal channel
// assumes the front end model and the bound checker
`default_nettype none
module tmc_channel_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'h0, rst_n = 1'h0, wr = 1'h0, go = 1'h0, pol = 1'h0, dop = 1'h0, dsh = 1'h0, vld, rs, tv, aa, ab;
    logic [1:0]  topo = 2'h2, coef = 2'h0, topo_o;
    logic [13:0] emit = 14'h08ee, emit_o;
    logic [8:0]  offs = 9'h000, ta = 9'h001, tb = 9'h009;
    logic [6:0]  ha = 7'h7f, hb = 7'h00;
    logic [3:0]  da = 4'h2, db = 4'h0;
    logic [10:0] val = 11'h000, smpl, temp, temp_i;
    logic [10:0] avg_e [4] = '{11'h07f, 11'h00f, 11'h007, 11'h07f};
    int          n_errors = 0, comparisons = 0;
    always #20 clk = ~clk;
    tmc_front_end u_tmc_front_end (.i_clk(clk), .i_go(go), .i_value(val), .o_vld(vld), .o_sample(smpl));
    tmc_channel #(.REMOTE(1)) u_tmc_channel (.I_CLK(clk), .I_RST_N(rst_n), .I_CFG_WR(wr), .I_EMIT_CODE(emit),
        .I_TOPOLOGY(topo), .I_OFFSET(offs), .I_ALARM_A_THRESHOLD(ta), .I_ALARM_B_THRESHOLD(tb),
        .I_FAULT_READING_POLARITY(pol), .I_AVERAGE_COEFFICIENT_SELECT(coef), .I_ALARM_A_DEPTH(da),
        .I_ALARM_B_DEPTH(db), .I_ALARM_A_HYSTERESIS(ha), .I_ALARM_B_HYSTERESIS(hb), .I_SAMPLE_VLD(vld),
        .I_SAMPLE(smpl), .I_DIODE_OPEN(dop), .I_DIODE_SHORT(dsh), .O_EMIT_CODE(emit_o), .O_TOPOLOGY(topo_o),
        .O_FE_RESTART(rs), .O_TEMP(temp), .O_TEMP_VLD(tv), .O_ALARM_COMPARATOR_A(aa), .O_ALARM_COMPARATOR_B(ab));
    tmc_channel #(.REMOTE(0)) u_tmc_channel_int (.I_CLK(clk), .I_RST_N(rst_n), .I_CFG_WR(wr), .I_EMIT_CODE(emit),
        .I_TOPOLOGY(topo), .I_OFFSET(offs), .I_ALARM_A_THRESHOLD(ta), .I_ALARM_B_THRESHOLD(tb),
        .I_FAULT_READING_POLARITY(pol), .I_AVERAGE_COEFFICIENT_SELECT(coef), .I_ALARM_A_DEPTH(da),
        .I_ALARM_B_DEPTH(db), .I_ALARM_A_HYSTERESIS(ha), .I_ALARM_B_HYSTERESIS(hb), .I_SAMPLE_VLD(vld),
        .I_SAMPLE(smpl), .I_DIODE_OPEN(dop), .I_DIODE_SHORT(dsh), .O_EMIT_CODE(), .O_TOPOLOGY(),
        .O_FE_RESTART(), .O_TEMP(temp_i), .O_TEMP_VLD(), .O_ALARM_COMPARATOR_A(), .O_ALARM_COMPARATOR_B());
    task automatic tally_and_finish;
        if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
        comparisons++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // config write pulse, then one idle cycle so the next sample is taken
    task automatic cfg;
        wr = 1'h1;
        tick(1);
        wr = 1'h0;
        chk("restart", 14'h1, {13'h0, rs});
        tick(1);
    endtask
    task automatic smp(input logic [10:0] x, input logic [10:0] e, input logic v);
        go = 1'h1;
        val = x;
        tick(1);
        go = 1'h0;
        tick(2);
        chk("temp_vld", {13'h0, v}, {13'h0, tv});
        chk("temp", {3'h0, e}, {3'h0, temp});
    endtask
    task automatic t_average;
        offs = 9'h1ff;
        for (int i = 0; i < 4; i++) begin
            coef = i[1:0];
            cfg();
            smp(11'h000, 11'h7ff, 1'h1);
            smp(11'h080, avg_e[i], 1'h1);
        end
    endtask
    task automatic t_topology;
        for (int t = 0; t < 4; t++) begin
            topo = t[1:0];
            emit = 14'h08ee + {12'h0, t[1:0]};
            cfg();
            chk("topology", {12'h0, topo}, {12'h0, topo_o});
            chk("emit_code", emit, emit_o);
            smp(11'h0aa, t == 0 ? 11'h07f : 11'h0a9, t != 0);
        end
    endtask
    task automatic t_fault;
        for (int c = 0; c < 4; c++) begin
            pol = c[1];
            dsh = !c[0];
            dop = c[0];
            cfg();
            tick(2);
            smp(11'h010, (c == 1 || c == 2) ? 11'h401 : 11'h3ff, 1'h1);
            chk("internal_temp", 14'h000f, {3'h0, temp_i});
        end
        dop = 1'h0;
    endtask
    task automatic t_alarm;
        cfg();
        for (int k = 0; k < 6; k++) begin
            smp(k < 3 ? 11'h009 : 11'h003, k < 3 ? 11'h008 : 11'h002, 1'h1);
            tick(1);
            chk("alarm_a", {13'h0, k >= 2}, {13'h0, aa});
            chk("alarm_b", 14'h0, {13'h0, ab});
        end
        cfg();
        chk("alarm_a", 14'h0, {13'h0, aa});
    endtask
    initial begin
        tick(5);
        chk("emit_code", 14'h11dc, emit_o);
        chk("topology", 14'h1, {12'h0, topo_o});
        chk("reset_state", 14'h0, {rs | tv, aa, ab, temp});
        rst_n = 1'h1;
        tick(1);
        t_average();
        t_topology();
        t_fault();
        t_alarm();
        tally_and_finish();
    end
    initial begin
        #40000;
        n_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
